// [logic/fpad_pkg.sv]
package fpad_pkg;
   // ==========================================================
   // register map, byte offsets on the avalon slave
   localparam int          FPAD_AVS_AW       = 6;
   localparam logic [5:0]  FPAD_OFF_SWITCH   = 6'h00;
   localparam logic [5:0]  FPAD_OFF_ADDR     = 6'h04;
   localparam logic [5:0]  FPAD_OFF_DATA     = 6'h08;
   localparam logic [5:0]  FPAD_OFF_CMD      = 6'h0C;
   localparam logic [5:0]  FPAD_OFF_PC       = 6'h10;
   localparam logic [5:0]  FPAD_OFF_KEYS     = 6'h14;
   localparam logic [5:0]  FPAD_OFF_PSEG     = 6'h18;
   localparam logic [5:0]  FPAD_OFF_ZVEC     = 6'h1C;
   localparam logic [5:0]  FPAD_OFF_SAVEKEYS = 6'h20;
   // ==========================================================
   // reset values
   localparam logic [15:0] FPAD_RST_SWITCH   = 16'h0000;
   localparam logic [15:0] FPAD_RST_WORD     = 16'h0000;
   localparam logic [11:0] FPAD_RST_SEG      = 12'h000;
   // ==========================================================
   // address widths and wrap masks
   localparam int          FPAD_REG_DEPTH    = 128;
   localparam int          FPAD_REG_AW       = 7;
   localparam logic [15:0] FPAD_MASK_CRS     = 16'h001F;
   localparam logic [15:0] FPAD_MASK_FILE    = 16'h007F;
   localparam logic [15:0] FPAD_MASK_MEM     = 16'hFFFF;
   localparam logic [15:0] FPAD_LEGACY_TOP   = 16'h001F;
   // register file regions, index bits 6:5
   localparam logic [1:0]  FPAD_RGN_SYSTEM   = 2'h0;
   localparam logic [1:0]  FPAD_RGN_DMA      = 2'h1;
   localparam logic [1:0]  FPAD_RGN_USER2    = 2'h2;
   localparam logic [1:0]  FPAD_RGN_USER3    = 2'h3;
   // ==========================================================
   // command codes, low bits of a write to the command offset
   typedef enum logic [2:0] {
      FPAD_OP_NONE     = 3'h0,
      FPAD_OP_FETCH    = 3'h1,
      FPAD_OP_STORE    = 3'h2,
      FPAD_OP_INCFETCH = 3'h3,
      FPAD_OP_INCSTORE = 3'h4,
      FPAD_OP_ENTER    = 3'h5,
      FPAD_OP_RESUME   = 3'h6
   } fpad_op_t;
   typedef enum logic [1:0] {
      FPAD_ST_IDLE   = 2'b00,
      FPAD_ST_SAMPLE = 2'b01,
      FPAD_ST_ACCESS = 2'b11,
      FPAD_ST_DONE   = 2'b10
   } fpad_state_t;
   // ==========================================================
   // switch word, bit 0 upward: target, file, half/translation,
   // segment number (low six = physical high bits), segmentation
   typedef struct packed {
      logic        seg_enable;
      logic [11:0] segment_number_switches;
      logic        half_or_translation_switch;
      logic        file_select_switch;
      logic        target_select_switch;
   } fpad_sw_t;
   typedef struct packed {
      logic        req;
      logic        write;
      logic        mapped;
      logic        trap_en;
      logic [11:0] segment;
      logic [21:0] addr;
      logic [15:0] wdata;
   } fpad_mem_req_t;
endpackage

// [logic/fpad_wrap_inc.sv]
`timescale 1ns/1ps
module fpad_wrap_inc #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] mask,
   output logic      [W-1:0] result
);
   // ==========================================================
   // increment inside mask, bits above it kept as they are
   wire logic [W-1:0] plus_one = value + {{(W-1){1'b0}}, 1'b1};
   assign result = (value & ~mask) | (plus_one & mask);
endmodule

// [logic/fpad_regfile.sv]
`timescale 1ns/1ps
module fpad_regfile #(
   parameter int DEPTH = 128,
   parameter int AW    = 7,
   parameter int W     = 32
) (
   input  wire logic           clock,
   input  wire logic           rst_n,
   input  wire logic           we,
   input  wire logic           hi_sel,
   input  wire logic [AW-1:0]  addr,
   input  wire logic [W/2-1:0] wdata,
   output logic      [W-1:0]   rdata
);
   // ==========================================================
   // register file storage, half-word writes, registered read
   logic [W-1:0] mem [DEPTH];
   always_ff @(posedge clock) begin
      if (we && hi_sel) begin
         mem[addr][W-1:W/2] <= wdata;
      end
      if (we && !hi_sel) begin
         mem[addr][W/2-1:0] <= wdata;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem[addr];
      end
   end
endmodule

// [logic/fpad_panel.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - with every switch down a panel fetch or store goes to memory, mapped.
// - with segmentation off, mapped and absolute memory references resolve alike.
// - with segmentation on, absolute memory access takes the low six segment switches as physical bits 21:16.
// - with segmentation on, mapped memory access reads all twelve segment switches as the segment number.
// - with segmentation on, mapped references go to segment zero unless switches say otherwise.
// - only mapped memory references may raise address traps; absolute never does.
// - with all switches down, addresses 0 to 37 octal reach legacy registers by trapping.
// - register target with file switch down uses the low five address bits only.
// - register target with file switch up decodes all seven address bits.
// - register index regions: system, dma, user set 2, user set 3 by bits 6:5.
// - the half switch picks the upper sixteen bits when up, the lower when down.
// - increment operations advance the address before the access, for registers too.
// - the increment wraps in sixteen bits for memory, in the active five or seven for registers, higher bits are ignored.
// - panel entry copies the pc to the address reg, its word to the data reg, saves keys.
// - resume reloads the pc and the full keys from the panel-held values.
// - a zero-vector event leaves pc, segment, saved keys, zeroed panel regs and the vector address.
module fpad_panel
   import fpad_pkg::*;
#(
   parameter int REG_DEPTH = FPAD_REG_DEPTH
) (
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   input  wire logic [FPAD_AVS_AW-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   output fpad_mem_req_t               mem_cmd,
   input  wire logic                   mem_ack,
   input  wire logic [15:0]            mem_rdata,
   input  wire logic                   zvec_event,
   input  wire logic [15:0]            zvec_pc,
   input  wire logic [11:0]            zvec_seg,
   input  wire logic [15:0]            zvec_keys,
   input  wire logic [15:0]            zvec_vector,
   output logic      [15:0]            program_counter,
   output logic      [11:0]            procedure_segment,
   output logic      [15:0]            cpu_keys,
   output logic                        busy
);
   // ==========================================================
   // reset release
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================
   // state
   fpad_state_t state;
   fpad_op_t    op;
   fpad_sw_t    sw_live;
   fpad_sw_t    sw_q;
   logic [15:0] panel_address_reg;
   logic [15:0] panel_data_reg;
   logic [15:0] zero_vector_addr_reg;
   logic [15:0] saved_keys_high;
   logic        bus_ack;
   logic        last_reg;
   logic [1:0]  last_region;
   logic [31:0] rf_rdata;

   // ==========================================================
   // bus decode
   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
      lane16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction
   wire logic        bus_req    = avs_read | avs_write;
   wire logic        wr_go      = avs_write & bus_ack;
   wire logic [15:0] wd         = avs_writedata[15:0];
   wire logic [1:0]  be         = avs_byteenable[1:0];
   wire logic        wr_switch  = wr_go && avs_address == FPAD_OFF_SWITCH;
   wire logic        wr_addr    = wr_go && avs_address == FPAD_OFF_ADDR;
   wire logic        wr_data    = wr_go && avs_address == FPAD_OFF_DATA;
   wire logic        wr_cmd     = wr_go && avs_address == FPAD_OFF_CMD && be[0];
   wire logic        wr_pc      = wr_go && avs_address == FPAD_OFF_PC;
   wire logic        wr_keys    = wr_go && avs_address == FPAD_OFF_KEYS;
   wire logic        wr_pseg    = wr_go && avs_address == FPAD_OFF_PSEG;
   wire fpad_op_t    cmd_code   = fpad_op_t'(wd[2:0]);
   wire logic [15:0] pseg_lane  = lane16({4'h0, procedure_segment}, wd, be);
   wire logic        start      = wr_cmd && state == FPAD_ST_IDLE && cmd_code != FPAD_OP_NONE
                                  && cmd_code <= FPAD_OP_ENTER;
   wire logic        resume     = wr_cmd && state == FPAD_ST_IDLE && cmd_code == FPAD_OP_RESUME;
   wire logic [31:0] status_word = {26'h000_0000, last_region, last_reg,
                                    sw_q.target_select_switch, state != FPAD_ST_IDLE,
                                    mem_cmd.trap_en};
   wire logic [31:0] next_readdata =
      avs_address == FPAD_OFF_SWITCH   ? {16'h0000, sw_live} :
      avs_address == FPAD_OFF_ADDR     ? {16'h0000, panel_address_reg} :
      avs_address == FPAD_OFF_DATA     ? {16'h0000, panel_data_reg} :
      avs_address == FPAD_OFF_CMD      ? status_word :
      avs_address == FPAD_OFF_PC       ? {16'h0000, program_counter} :
      avs_address == FPAD_OFF_KEYS     ? {16'h0000, cpu_keys} :
      avs_address == FPAD_OFF_PSEG     ? {20'h0_0000, procedure_segment} :
      avs_address == FPAD_OFF_ZVEC     ? {16'h0000, zero_vector_addr_reg} :
      avs_address == FPAD_OFF_SAVEKEYS ? {16'h0000, saved_keys_high} : 32'h0000_0000;
   assign avs_waitrequest = bus_req & ~bus_ack;
   assign busy            = state != FPAD_ST_IDLE;

   // ==========================================================
   // access decode from the held switches
   wire logic        entering  = op == FPAD_OP_ENTER;
   wire logic        is_mem    = entering | ~sw_q.target_select_switch;
   wire logic        is_store  = op == FPAD_OP_STORE || op == FPAD_OP_INCSTORE;
   wire logic        absolute  = ~entering & sw_q.half_or_translation_switch;
   wire logic        seg_on    = sw_q.seg_enable;
   wire logic [11:0] map_seg   = seg_on ? sw_q.segment_number_switches : FPAD_RST_SEG;
   wire logic [5:0]  phys_high = seg_on ? sw_q.segment_number_switches[5:0] : 6'h00;
   wire logic [11:0] next_seg  = entering ? procedure_segment : absolute ? FPAD_RST_SEG : map_seg;
   wire logic [21:0] next_maddr = entering ? {6'h00, program_counter} :
                                  absolute ? {phys_high, panel_address_reg} :
                                             {6'h00, panel_address_reg};
   wire logic [15:0] reg_mask  = sw_q.file_select_switch ? FPAD_MASK_FILE : FPAD_MASK_CRS;
   wire logic [15:0] reg_sel   = panel_address_reg & reg_mask;
   wire logic [FPAD_REG_AW-1:0] reg_index = reg_sel[FPAD_REG_AW-1:0];
   wire logic [1:0]  region    = reg_index[6:5];
   wire logic        rf_we     = state == FPAD_ST_ACCESS && !is_mem && is_store;
   wire logic        hi_half   = sw_q.half_or_translation_switch;
   wire logic [15:0] rf_half   = hi_half ? rf_rdata[31:16] : rf_rdata[15:0];

   // ==========================================================
   // pre-access increment, width from the switches being sampled
   function automatic logic cmd_is_inc(input fpad_op_t o);
      cmd_is_inc = o == FPAD_OP_INCFETCH || o == FPAD_OP_INCSTORE;
   endfunction
   wire logic        inc_op    = cmd_is_inc(op);
   wire logic [15:0] inc_mask  = !sw_live.target_select_switch ? FPAD_MASK_MEM :
                                 sw_live.file_select_switch ? FPAD_MASK_FILE : FPAD_MASK_CRS;
   logic [15:0] inc_addr;
   fpad_wrap_inc #(
      .W      (16)
   ) u_inc (
      .value  (panel_address_reg),
      .mask   (inc_mask),
      .result (inc_addr)
   );

   fpad_regfile #(
      .DEPTH  (REG_DEPTH),
      .AW     (FPAD_REG_AW),
      .W      (32)
   ) u_rf (
      .clock  (clock),
      .rst_n  (rst_n),
      .we     (rf_we),
      .hi_sel (hi_half),
      .addr   (reg_index),
      .wdata  (panel_data_reg),
      .rdata  (rf_rdata)
   );

   // ==========================================================
   // bus slave
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack      <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         bus_ack      <= bus_req & ~bus_ack;
         avs_readdata <= next_readdata;
      end
   end

   // ==========================================================
   // operation sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= FPAD_ST_IDLE;
         op    <= FPAD_OP_NONE;
         sw_q  <= fpad_sw_t'(FPAD_RST_SWITCH);
      end else begin
         unique case (state)
            FPAD_ST_IDLE: begin
               if (start) begin
                  op    <= cmd_code;
                  state <= FPAD_ST_SAMPLE;
               end
            end
            FPAD_ST_SAMPLE: begin
               sw_q  <= sw_live;
               state <= FPAD_ST_ACCESS;
            end
            FPAD_ST_ACCESS: begin
               if (!is_mem || mem_ack) begin
                  state <= FPAD_ST_DONE;
               end
            end
            FPAD_ST_DONE: begin
               state <= FPAD_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // memory request, held until acknowledged
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_cmd <= '0;
      end else if (state == FPAD_ST_ACCESS && is_mem && !mem_cmd.req) begin
         mem_cmd.req     <= 1'b1;
         mem_cmd.write   <= is_store && !entering;
         mem_cmd.mapped  <= ~absolute & (entering | seg_on);
         mem_cmd.trap_en <= ~absolute;
         mem_cmd.segment <= next_seg;
         mem_cmd.addr    <= next_maddr;
         mem_cmd.wdata   <= panel_data_reg;
      end else if (mem_ack) begin
         mem_cmd.req <= 1'b0;
      end
   end

   // ==========================================================
   // panel-visible registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sw_live              <= fpad_sw_t'(FPAD_RST_SWITCH);
         panel_address_reg    <= FPAD_RST_WORD;
         panel_data_reg       <= FPAD_RST_WORD;
         zero_vector_addr_reg <= FPAD_RST_WORD;
         saved_keys_high      <= FPAD_RST_WORD;
         program_counter      <= FPAD_RST_WORD;
         procedure_segment    <= FPAD_RST_SEG;
         cpu_keys             <= FPAD_RST_WORD;
         last_reg             <= 1'b0;
         last_region          <= FPAD_RGN_SYSTEM;
      end else begin
         if (wr_switch) sw_live <= fpad_sw_t'(lane16(sw_live, wd, be));
         if (wr_addr && !busy) panel_address_reg <= lane16(panel_address_reg, wd, be);
         if (wr_data && !busy) panel_data_reg <= lane16(panel_data_reg, wd, be);
         if (wr_pc) program_counter <= lane16(program_counter, wd, be);
         if (wr_keys) cpu_keys <= lane16(cpu_keys, wd, be);
         if (wr_pseg) procedure_segment <= pseg_lane[11:0];
         if (state == FPAD_ST_SAMPLE && inc_op) begin
            panel_address_reg <= inc_addr;
         end
         if (state == FPAD_ST_SAMPLE && entering) begin
            panel_address_reg <= program_counter;
            saved_keys_high   <= cpu_keys;
         end
         if (state == FPAD_ST_ACCESS && is_mem && mem_ack && !mem_cmd.write) begin
            panel_data_reg <= mem_rdata;
         end
         if (state == FPAD_ST_DONE && !is_mem && !is_store) begin
            panel_data_reg <= rf_half;
         end
         if (state == FPAD_ST_DONE) begin
            last_reg    <= ~is_mem;
            last_region <= region;
         end
         if (resume) begin
            program_counter <= panel_address_reg;
            cpu_keys        <= saved_keys_high;
         end
         if (zvec_event) begin
            program_counter      <= zvec_pc;
            procedure_segment    <= zvec_seg;
            saved_keys_high      <= zvec_keys;
            panel_data_reg       <= FPAD_RST_WORD;
            panel_address_reg    <= FPAD_RST_WORD;
            zero_vector_addr_reg <= zvec_vector;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   wire logic all_down = !sw_q.target_select_switch && !sw_q.file_select_switch &&
                         !sw_q.half_or_translation_switch && sw_q.segment_number_switches == 12'h000;

   property p_all_down_mapped;
      (state == FPAD_ST_ACCESS && !entering && all_down && !mem_cmd.req)
         |=> (mem_cmd.req && mem_cmd.trap_en);
   endproperty
   a_all_down_mapped: assert property (p_all_down_mapped) else $error("all-down not mapped");

   property p_seg_off_same;
      (mem_cmd.req && !sw_q.seg_enable && !entering) |-> (mem_cmd.addr[21:16] == 6'h00
                                                          && mem_cmd.segment == 12'h000);
   endproperty
   a_seg_off_same: assert property (p_seg_off_same) else $error("seg off differs");

   property p_abs_high;
      (mem_cmd.req && !entering && sw_q.half_or_translation_switch && sw_q.seg_enable)
         |-> mem_cmd.addr[21:16] == sw_q.segment_number_switches[5:0];
   endproperty
   a_abs_high: assert property (p_abs_high) else $error("physical high bits wrong");

   property p_map_seg;
      (mem_cmd.req && !entering && !sw_q.half_or_translation_switch && sw_q.seg_enable)
         |-> mem_cmd.segment == sw_q.segment_number_switches;
   endproperty
   a_map_seg: assert property (p_map_seg) else $error("mapped segment wrong");

   property p_trap_only_mapped;
      mem_cmd.req |-> (mem_cmd.trap_en == (entering || !sw_q.half_or_translation_switch));
   endproperty
   a_trap_only_mapped: assert property (p_trap_only_mapped) else $error("trap enable wrong");

   property p_inc_crs_wrap;
      (state == FPAD_ST_SAMPLE && inc_op && !zvec_event &&
       sw_live.target_select_switch && !sw_live.file_select_switch)
         |=> (panel_address_reg[4:0] == $past(panel_address_reg[4:0]) + 5'h01) &&
             (panel_address_reg[15:5] == $past(panel_address_reg[15:5]));
   endproperty
   a_inc_crs_wrap: assert property (p_inc_crs_wrap) else $error("register wrap wrong");

   property p_entry_copy;
      (state == FPAD_ST_SAMPLE && entering && !zvec_event)
         |=> panel_address_reg == $past(program_counter) && saved_keys_high == $past(cpu_keys);
   endproperty
   a_entry_copy: assert property (p_entry_copy) else $error("entry copy wrong");

   property p_resume;
      (resume && !zvec_event && !wr_pc)
         |=> program_counter == $past(panel_address_reg) && cpu_keys == $past(saved_keys_high);
   endproperty
   a_resume: assert property (p_resume) else $error("resume reload wrong");

   property p_zvec;
      zvec_event |=> panel_data_reg == 16'h0000 && panel_address_reg == 16'h0000 &&
                     zero_vector_addr_reg == $past(zvec_vector) && program_counter == $past(zvec_pc);
   endproperty
   a_zvec: assert property (p_zvec) else $error("zero vector state wrong");

   property p_sw_hold;
      (state == FPAD_ST_ACCESS || state == FPAD_ST_DONE) |=> $stable(sw_q);
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("switches changed mid access");

   property p_bus_answer;
      (bus_req && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   c_reg_fetch: cover property (state == FPAD_ST_DONE && !is_mem && !is_store);
   c_mem_abs:   cover property (mem_cmd.req && !mem_cmd.trap_en && mem_ack);
   c_entry:     cover property (state == FPAD_ST_DONE && entering);
   c_zvec:      cover property (zvec_event);
endmodule

// [bench/fpad_mem_model.sv]
`timescale 1ns/1ps
// ====
// memory partner: acks after dly cycles, word = addr ^ 16'h5A5A
module fpad_mem_model
   import fpad_pkg::*;
(
   input  wire logic          clock,
   input  wire fpad_mem_req_t mem_cmd,
   input  wire logic [3:0]    dly,
   output logic               mem_ack,
   output logic [15:0]        mem_rdata,
   output fpad_mem_req_t      last_cmd
);
   logic [3:0] cnt = 4'h0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      last_cmd = '0;
   end
   always @(posedge clock) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_cmd.req && !mem_ack) begin
         if (cnt == dly) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_cmd.addr[15:0] ^ 16'h5A5A;
            last_cmd  <= mem_cmd;
            cnt       <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench
   import fpad_pkg::*;
;
   logic          clock, arst_n, avs_read, avs_write, avs_waitrequest, mem_ack;
   logic          zvec_event, busy, wr_q;
   logic [5:0]    avs_address;
   logic [31:0]   avs_writedata, avs_readdata, rd_q;
   logic [15:0]   mem_rdata, zvec_pc, zvec_keys, zvec_vector, program_counter, cpu_keys, q;
   logic [11:0]   zvec_seg, procedure_segment;
   logic [3:0]    dly;
   fpad_mem_req_t mem_cmd, last_cmd;
   int            failures, tests_run;
   fpad_panel fpad_panel_inst (.avs_byteenable(4'h3), .*);
   fpad_mem_model fpad_mem_model_inst (.*);
   // ====
   // clock, sampled bus copies, tasks
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(negedge clock) begin
      wr_q = avs_waitrequest;
      rd_q = avs_readdata;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= {16'h0000, d};
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clock); while (wr_q !== 1'b0);
      q = rd_q[15:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      chk(q, e);
   endtask
   task automatic op(input logic [15:0] sw, input logic [15:0] ad, input logic [2:0] c);
      bus(1'b1, FPAD_OFF_SWITCH, sw);
      bus(1'b1, FPAD_OFF_ADDR, ad);
      bus(1'b1, FPAD_OFF_CMD, {13'h0000, c});
      @(negedge clock);
      while (busy !== 1'b0) @(negedge clock);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      end_sim;
   end
   // ====
   // scenarios
   initial begin
      {arst_n, avs_read, avs_write, zvec_event, avs_address, avs_writedata} = '0;
      {zvec_pc, zvec_seg, zvec_keys, zvec_vector, dly} = '0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(FPAD_OFF_SWITCH, 16'h0000);
      rd(6'h3C, 16'h0000);
      op(16'h0000, 16'h001F, FPAD_OP_FETCH);
      rd(FPAD_OFF_DATA, 16'h5A45);
      chk(16'(last_cmd.trap_en), 16'h0001);
      chk(16'(last_cmd.mapped), 16'h0000);
      op(16'h0004, 16'h001F, FPAD_OP_FETCH);
      rd(FPAD_OFF_DATA, 16'h5A45);
      chk(16'(last_cmd.trap_en), 16'h0000);
      $display("test memory legacy done");
      dly <= 4'h3;
      op(16'hD5E0, 16'h0010, FPAD_OP_FETCH);
      chk({4'h0, last_cmd.segment}, 16'h0ABC);
      chk(16'(last_cmd.mapped), 16'h0001);
      op(16'h8000, 16'h0010, FPAD_OP_FETCH);
      chk({4'h0, last_cmd.segment}, 16'h0000);
      bus(1'b1, FPAD_OFF_DATA, 16'h1234);
      op(16'hFE2C, 16'h0100, FPAD_OP_STORE);
      chk({10'h000, last_cmd.addr[21:16]}, 16'h0005);
      chk(last_cmd.wdata, 16'h1234);
      chk(16'(last_cmd.write), 16'h0001);
      chk(16'(last_cmd.trap_en), 16'h0000);
      $display("test memory segments done");
      bus(1'b1, FPAD_OFF_DATA, 16'hBEEF);
      op(16'h0001, 16'h0021, FPAD_OP_STORE);
      bus(1'b1, FPAD_OFF_DATA, 16'hCAFE);
      op(16'h0005, 16'h0021, FPAD_OP_STORE);
      op(16'h0005, 16'h0001, FPAD_OP_FETCH);
      rd(FPAD_OFF_DATA, 16'hCAFE);
      op(16'h0001, 16'h0001, FPAD_OP_FETCH);
      rd(FPAD_OFF_DATA, 16'hBEEF);
      $display("test register halves done");
      bus(1'b1, FPAD_OFF_DATA, 16'h1111);
      op(16'h0003, 16'h00FF, FPAD_OP_INCSTORE);
      rd(FPAD_OFF_ADDR, 16'h0080);
      op(16'h0001, 16'h003F, FPAD_OP_INCFETCH);
      rd(FPAD_OFF_ADDR, 16'h0020);
      rd(FPAD_OFF_DATA, 16'h1111);
      op(16'h0003, 16'h0041, FPAD_OP_FETCH);
      bus(1'b0, FPAD_OFF_CMD, 16'h0000);
      chk(q & 16'h0030, 16'h0020);
      $display("test register increment done");
      bus(1'b1, FPAD_OFF_PC, 16'h0200);
      bus(1'b1, FPAD_OFF_KEYS, 16'h00C3);
      op(16'h0000, 16'h0000, FPAD_OP_ENTER);
      rd(FPAD_OFF_ADDR, 16'h0200);
      rd(FPAD_OFF_DATA, 16'h585A);
      rd(FPAD_OFF_SAVEKEYS, 16'h00C3);
      bus(1'b1, FPAD_OFF_KEYS, 16'h0011);
      op(16'h0000, 16'h0300, FPAD_OP_RESUME);
      chk(program_counter, 16'h0300);
      chk(cpu_keys, 16'h00C3);
      $display("test entry and resume done");
      @(posedge clock);
      {zvec_pc, zvec_seg, zvec_keys, zvec_vector} <= {16'h0444, 12'h055, 16'h0066, 16'h0077};
      zvec_event <= 1'b1;
      @(posedge clock);
      zvec_event <= 1'b0;
      @(negedge clock);
      chk(program_counter, 16'h0444);
      chk({4'h0, procedure_segment}, 16'h0055);
      rd(FPAD_OFF_ADDR, 16'h0000);
      rd(FPAD_OFF_DATA, 16'h0000);
      rd(FPAD_OFF_ZVEC, 16'h0077);
      rd(FPAD_OFF_SAVEKEYS, 16'h0066);
      $display("test zero vector done");
      end_sim;
   end
endmodule
